/* File: logic/vpi_pkg.sv */
package vpi_pkg;

    // ==========================================================
    // vector space
    localparam int NUM_TRAPS = 8;
    localparam int NUM_IRQ = 118;
    localparam int NUM_VEC = 126;
    localparam int VEC_W = 24;
    localparam int PRIO_W = 3;
    localparam int LVL_W = 4;
    localparam int VNUM_W = 8;
    localparam int CODE_W = 7;
    localparam logic [VNUM_W-1:0] VEC_CODE_OFFSET = 8'h08;
    localparam logic [LVL_W-1:0] LVL_MAX = 4'hF;
    localparam logic [VEC_W-1:0] RESET_ADDR = 24'h000000;
    localparam logic [VEC_W-1:0] PRIMARY_BASE = 24'h000004;
    localparam logic [VEC_W-1:0] VEC_STEP = 24'h000002;
    localparam logic [VEC_W-1:0] ALT_BASE = 24'h000100;

    // ==========================================================
    // register map, byte addresses on the bus
    localparam int ADR_W = 12;
    localparam logic [ADR_W-1:0] ADDR_CTRL_TWO = 12'h000;
    localparam logic [ADR_W-1:0] ADDR_STATUS = 12'h004;
    localparam logic [ADR_W-1:0] ADDR_EVT_STATUS = 12'h008;
    localparam logic [ADR_W-1:0] ADDR_EVT_MASK = 12'h00C;
    localparam logic [ADR_W-1:0] ADDR_PRIO_BASE = 12'h100;
    localparam logic [ADR_W-1:0] ADDR_VEC_BASE = 12'h800;
    localparam int PRIO_PER_REG = 4;
    localparam int PRIO_TIMER4_COMPARE_IDX = 6;
    localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;

    // ==========================================================
    // field positions
    localparam int CTRL_ALT_BIT = 15;
    localparam int ST_UNACK_BIT = 15;
    localparam int ST_CAPSEL_BIT = 13;
    localparam int ST_LVL_LSB = 8;
    localparam int ST_CODE_LSB = 0;
    localparam int EVT_W = 3;
    localparam int EVT_TAKEN = 0;
    localparam int EVT_TRAP = 1;
    localparam int EVT_STALL = 2;

    // ==========================================================
    // fixed latencies, in clock cycles
    localparam int ENTRY_CYCLES = 5;
    localparam int RETURN_CYCLES = 3;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ENTRY,
        ST_RETURN
    } vpi_fsm_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [ADR_W-1:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } vpi_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } vpi_wb_rsp_t;

    typedef struct packed {
        logic irq;
        logic [LVL_W-1:0] req_level;
        logic [VNUM_W-1:0] req_vec;
        logic [VEC_W-1:0] fetch_addr;
        logic [VEC_W-1:0] handler;
        logic entry_done;
        logic ret_done;
    } vpi_cpu_out_t;

endpackage

/* File: logic/vpi_ctrl.sv */
`timescale 1ns/100ps
// Contract
// - all peripheral requests merge into one request line to the core
// - eight non-maskable trap inputs are handled besides the maskable sources
// - seven user priority levels, fixed order within a level
// - primary table at 000004h, 126 vectors: 8 traps then 118 sources
// - each vector entry is a 24-bit handler address given on entry
// - equal priority ties go to the lower vector number
// - alternate-table bit 15 of control two selects the following table
// - reset bypasses the controller, clears registers except priority fields (load 100), execution starts at 000000h
// - entry and return each take a fixed cycle count for any source
// - 3-bit field: 111 level 7, 001 level 1, 000 disables source
// - unacked flag set while request is held off by CPU priority
// - capture select picks pending vector or last acknowledged vector
// - status bits 11..8 show the new CPU priority level
// - status bits 6..0 hold vector number minus eight
module vpi_ctrl
    import vpi_pkg::*;
#(
    parameter int N_IRQ = NUM_IRQ,
    parameter int ENTRY_CYC = ENTRY_CYCLES,
    parameter int RET_CYC = RETURN_CYCLES
) (
    input wire logic i_clk, // system clock
    input wire logic i_rst_n, // synchronous reset, active low
    input wire vpi_wb_req_t i_wb, // wishbone request
    output vpi_wb_rsp_t o_wb, // wishbone answer
    input wire logic [N_IRQ-1:0] i_irq, // peripheral request levels
    input wire logic [NUM_TRAPS-1:0] i_trap, // trap request levels
    input wire logic [LVL_W-1:0] i_cpu_level, // current CPU priority
    input wire logic i_ack, // core takes the request, pulse
    input wire logic i_ret, // core starts a return, pulse
    output vpi_cpu_out_t o_cpu, // request and vector to the core
    output logic o_int // summary event interrupt, level
);

    // ==========================================================
    // sizes
    localparam int N_VEC = NUM_TRAPS + N_IRQ;
    localparam int N_TAB = 2 * N_VEC;
    localparam int N_PREG = (N_IRQ + PRIO_PER_REG - 1) / PRIO_PER_REG;
    localparam int CNT_W = 8;

    typedef struct packed {
        vpi_fsm_t fsm;
        logic [CNT_W-1:0] cnt;
        logic alt;
        logic capsel;
        logic [LVL_W-1:0] new_lvl;
        logic [VNUM_W-1:0] last_vec;
        logic [VNUM_W-1:0] sel_vec;
        logic [LVL_W-1:0] sel_lvl;
        logic sel_ok;
        logic unack;
        logic [EVT_W-1:0] evt;
        logic [EVT_W-1:0] mask;
        logic [N_IRQ-1:0][PRIO_W-1:0] prio;
        logic [N_TAB-1:0][VEC_W-1:0] vtab;
        logic ack;
        logic [31:0] rdat;
        logic [VEC_W-1:0] fetch;
        logic [VEC_W-1:0] handler;
        logic entry_done;
        logic ret_done;
    } vpi_regs_t;

    vpi_regs_t r;
    vpi_regs_t next_r;

    // ==========================================================
    // scratch of the combinational process
    logic req;
    logic wr;
    logic [ADR_W-1:0] poff;
    logic [ADR_W-1:0] voff;
    logic [ADR_W-3:0] pidx;
    logic [ADR_W-3:0] vidx;
    logic pin;
    logic vin;
    logic [31:0] rd;
    logic [LVL_W-1:0] lv;
    logic pend;
    logic [LVL_W-1:0] best_l;
    logic [VNUM_W-1:0] best_v;
    logic best_p;
    logic best_trap;
    logic elig;
    logic [EVT_W-1:0] evt_set;
    logic [VNUM_W-1:0] shown;
    int src;
    int tix;

    // ==========================================================
    // next-state logic
    always_comb begin
        next_r = r;
        rd = '0;
        lv = '0;
        pend = 1'b0;
        best_l = '0;
        best_v = '0;
        best_p = 1'b0;
        src = 0;
        tix = 0;
        evt_set = '0;
        req = i_wb.cyc & i_wb.stb;
        // write lands on the edge that the master sees ack
        wr = req & i_wb.we & r.ack;
        poff = i_wb.adr - ADDR_PRIO_BASE;
        voff = i_wb.adr - ADDR_VEC_BASE;
        pidx = poff[ADR_W-1:2];
        vidx = voff[ADR_W-1:2];
        pin = (i_wb.adr >= ADDR_PRIO_BASE) && (int'(pidx) < N_PREG) && (i_wb.adr < ADDR_VEC_BASE);
        vin = (i_wb.adr >= ADDR_VEC_BASE) && (int'(vidx) < N_TAB);

        // scan from the top so a later, lower vector wins an equal level
        for (int v = N_VEC - 1; v >= 0; v--) begin
            if (v < NUM_TRAPS) begin
                // traps sit above every user level and ignore the field
                pend = i_trap[v];
                lv = LVL_MAX - LVL_W'(v);
            end else begin
                pend = i_irq[v-NUM_TRAPS] && (r.prio[v-NUM_TRAPS] != '0);
                lv = {1'b0, r.prio[v-NUM_TRAPS]};
            end
            if (pend && (lv >= best_l)) begin
                best_l = lv;
                best_v = VNUM_W'(v);
                best_p = 1'b1;
            end
        end
        best_trap = best_p && (best_v < VEC_CODE_OFFSET);
        // non-maskable traps are taken at any CPU level
        elig = best_p && (best_trap || (best_l > i_cpu_level));

        // selection is held in flops so the core sees stable data
        next_r.sel_ok = elig;
        next_r.sel_vec = best_v;
        next_r.sel_lvl = best_l;
        next_r.unack = best_p && !elig;
        if (best_p && !elig && !r.unack) begin
            evt_set[EVT_STALL] = 1'b1;
        end

        // pending code or last taken, as software chooses
        shown = r.capsel ? r.sel_vec : r.last_vec;

        // ======================================================
        // register read mux
        if (i_wb.adr == ADDR_CTRL_TWO) begin
            rd[CTRL_ALT_BIT] = r.alt;
        end else if (i_wb.adr == ADDR_STATUS) begin
            rd[ST_UNACK_BIT] = r.unack;
            rd[ST_CAPSEL_BIT] = r.capsel;
            rd[ST_LVL_LSB +: LVL_W] = r.new_lvl;
            rd[ST_CODE_LSB +: CODE_W] = CODE_W'(shown - VEC_CODE_OFFSET);
        end else if (i_wb.adr == ADDR_EVT_STATUS) begin
            rd[EVT_W-1:0] = r.evt;
        end else if (i_wb.adr == ADDR_EVT_MASK) begin
            rd[EVT_W-1:0] = r.mask;
        end else if (pin) begin
            // fields for sources past the top read zero
            for (int j = 0; j < PRIO_PER_REG; j++) begin
                src = int'(pidx) * PRIO_PER_REG + j;
                if (src < N_IRQ) begin
                    rd[12-4*j +: PRIO_W] = r.prio[src];
                end
            end
        end else if (vin) begin
            rd[VEC_W-1:0] = r.vtab[vidx];
        end

        // ======================================================
        // bus slave: one wait state, unmapped reads zero and writes drop
        next_r.ack = req & ~r.ack;
        next_r.rdat = (req & ~r.ack) ? rd : '0;

        // ======================================================
        // register writes, byte lanes honoured
        if (wr) begin
            if (i_wb.adr == ADDR_CTRL_TWO && i_wb.sel[1]) begin
                next_r.alt = i_wb.dat[CTRL_ALT_BIT];
            end
            if (i_wb.adr == ADDR_STATUS && i_wb.sel[1]) begin
                next_r.capsel = i_wb.dat[ST_CAPSEL_BIT];
            end
            if (i_wb.adr == ADDR_EVT_MASK && i_wb.sel[0]) begin
                next_r.mask = i_wb.dat[EVT_W-1:0];
            end
            if (pin) begin
                for (int j = 0; j < PRIO_PER_REG; j++) begin
                    src = int'(pidx) * PRIO_PER_REG + j;
                    // unimplemented positions keep nothing
                    if (src < N_IRQ && i_wb.sel[1-j/2]) begin
                        next_r.prio[src] = i_wb.dat[12-4*j +: PRIO_W];
                    end
                end
            end
            if (vin) begin
                for (int b = 0; b < 3; b++) begin
                    if (i_wb.sel[b]) begin
                        next_r.vtab[vidx][8*b +: 8] = i_wb.dat[8*b +: 8];
                    end
                end
            end
        end

        // ======================================================
        // entry and return sequencer
        next_r.entry_done = 1'b0;
        next_r.ret_done = 1'b0;
        case (r.fsm)
            ST_IDLE: begin
                if (i_ack && r.sel_ok) begin
                    // freeze the presented vector for the whole entry
                    next_r.fsm = ST_ENTRY;
                    next_r.cnt = CNT_W'(ENTRY_CYC - 1);
                    next_r.last_vec = r.sel_vec;
                    next_r.new_lvl = r.sel_lvl;
                    // alternate table starts right behind the primary one
                    tix = r.alt ? N_VEC + int'(r.sel_vec) : int'(r.sel_vec);
                    next_r.fetch = (r.alt ? ALT_BASE : PRIMARY_BASE)
                        + VEC_W'(r.sel_vec) * VEC_STEP;
                    next_r.handler = r.vtab[tix];
                    evt_set[EVT_TAKEN] = 1'b1;
                    evt_set[EVT_TRAP] = r.sel_vec < VEC_CODE_OFFSET;
                end else if (i_ret) begin
                    next_r.fsm = ST_RETURN;
                    next_r.cnt = CNT_W'(RET_CYC - 1);
                end
            end
            ST_ENTRY: begin
                if (r.cnt == '0) begin
                    next_r.fsm = ST_IDLE;
                    next_r.entry_done = 1'b1;
                end else begin
                    next_r.cnt = r.cnt - 1'b1;
                end
            end
            ST_RETURN: begin
                if (r.cnt == '0) begin
                    next_r.fsm = ST_IDLE;
                    next_r.ret_done = 1'b1;
                end else begin
                    next_r.cnt = r.cnt - 1'b1;
                end
            end
            default: begin
                next_r.fsm = ST_IDLE;
            end
        endcase

        // ======================================================
        // sticky events: a fresh event beats a same-cycle clear
        if (wr && i_wb.adr == ADDR_EVT_STATUS && i_wb.sel[0]) begin
            next_r.evt = r.evt & ~i_wb.dat[EVT_W-1:0];
        end
        next_r.evt = next_r.evt | evt_set;
    end

    // ==========================================================
    // state register; reset is local and never routed via requests
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            r <= '0;
            r.fsm <= ST_IDLE;
            // no vector taken yet: the status code field reads zero
            r.last_vec <= VEC_CODE_OFFSET;
            for (int k = 0; k < N_IRQ; k++) begin
                r.prio[k] <= PRIO_RESET;
            end
        end else begin
            r <= next_r;
        end
    end

    // ==========================================================
    // outputs; irq drops while a sequence runs so no double take
    assign o_wb.ack = r.ack;
    assign o_wb.dat = r.rdat;
    assign o_cpu.irq = r.sel_ok && (r.fsm == ST_IDLE);
    assign o_cpu.req_level = r.sel_lvl;
    assign o_cpu.req_vec = r.sel_vec;
    assign o_cpu.fetch_addr = r.fetch;
    assign o_cpu.handler = r.handler;
    assign o_cpu.entry_done = r.entry_done;
    assign o_cpu.ret_done = r.ret_done;
    assign o_int = |(r.evt & r.mask);

endmodule

/* File: bench/vpi_monitor.sv */
`timescale 1ns/100ps
module vpi_monitor
    import vpi_pkg::*;
#(
    parameter int N_IRQ = NUM_IRQ,
    parameter int ENTRY_CYC = ENTRY_CYCLES,
    parameter int RET_CYC = RETURN_CYCLES
) (
    input wire logic i_clk, // clock
    input wire logic i_rst_n, // reset, active low
    input wire vpi_wb_req_t i_wb, // bus request
    input wire vpi_wb_rsp_t o_wb, // bus answer
    input wire logic [N_IRQ-1:0] i_irq, // sources
    input wire logic [NUM_TRAPS-1:0] i_trap, // traps
    input wire logic [LVL_W-1:0] i_cpu_level, // cpu level
    input wire logic i_ack, // take pulse
    input wire logic i_ret, // return pulse
    input wire vpi_cpu_out_t o_cpu, // core side
    input wire logic o_int // event interrupt
);
    logic alt;
    logic busy;
    logic take;
    logic ret_ok;
    assign take = i_ack && o_cpu.irq;
    assign ret_ok = i_ret && !busy && !take;
    // shadow of the table select and of a running sequence
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            alt <= 1'b0;
            busy <= 1'b0;
        end else begin
            if (i_wb.cyc && i_wb.stb && i_wb.we && o_wb.ack && i_wb.sel[1]
                && i_wb.adr == ADDR_CTRL_TWO) begin
                alt <= i_wb.dat[CTRL_ALT_BIT];
            end
            if (take || ret_ok) begin
                busy <= 1'b1;
            end else if (o_cpu.entry_done || o_cpu.ret_done) begin
                busy <= 1'b0;
            end
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_take;
        i_ack && o_cpu.irq;
    endsequence
    sequence s_entry;
        !o_cpu.irq [*5] ##1 o_cpu.entry_done;
    endsequence
    // ==========================================================
    // bus and core link timing
    a_bus_answer: assert property (i_wb.cyc && i_wb.stb && !o_wb.ack |=> o_wb.ack)
        else $error("bus request not answered next cycle");
    a_ack_pulse: assert property (o_wb.ack |=> !o_wb.ack)
        else $error("bus ack longer than one cycle");
    a_bus_quiet: assert property (!o_wb.ack |-> o_wb.dat == '0)
        else $error("read data outside ack");
    a_entry_walk: assert property (s_take |=> s_entry)
        else $error("entry timing wrong");
    a_done_pulse: assert property (o_cpu.entry_done |=> !o_cpu.entry_done)
        else $error("entry done longer than one cycle");
    a_return_time: assert property (ret_ok |-> ##(RET_CYC + 1) o_cpu.ret_done)
        else $error("return timing wrong");
    // ==========================================================
    // choice of vector
    a_fetch_addr: assert property (s_take |=> o_cpu.fetch_addr == ($past(alt) ? ALT_BASE
        : PRIMARY_BASE) + 24'({$past(o_cpu.req_vec), 1'b0}))
        else $error("table address wrong");
    a_trap_level: assert property (o_cpu.irq && o_cpu.req_vec < 8
        |-> o_cpu.req_level == LVL_MAX - o_cpu.req_vec[3:0])
        else $error("trap level wrong");
    a_src_level: assert property (o_cpu.irq && o_cpu.req_vec >= 8 |-> o_cpu.req_level
        inside {[1:7]} && o_cpu.req_level > $past(i_cpu_level))
        else $error("source presented at illegal level");
    a_trap_first: assert property (o_cpu.irq && o_cpu.req_vec >= 8
        |-> $past(i_trap) == '0)
        else $error("source presented over pending trap");
endmodule
bind vpi_ctrl vpi_monitor #(.N_IRQ(N_IRQ), .ENTRY_CYC(ENTRY_CYC), .RET_CYC(RET_CYC)) i_mon (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wb(i_wb), .o_wb(o_wb), .i_irq(i_irq),
    .i_trap(i_trap), .i_cpu_level(i_cpu_level), .i_ack(i_ack), .i_ret(i_ret),
    .o_cpu(o_cpu), .o_int(o_int));

/* File: bench/vpi_core_model.sv */
`timescale 1ns/100ps
module vpi_core_model
    import vpi_pkg::*;
(
    input wire logic i_clk, // clock
    input wire logic i_rst_n, // reset, active low
    input wire logic i_en, // allow takes
    input wire logic [2:0] i_delay, // cycles before ack
    input wire vpi_cpu_out_t i_cpu, // controller outputs
    output logic o_ack = 1'b0, // take pulse
    output logic o_ret = 1'b0 // return pulse
);
    logic busy;
    logic [2:0] w;
    logic [1:0] gap;
    // one take at a time; return starts two cycles after entry ends
    always @(posedge i_clk) begin
        o_ack <= 1'b0;
        o_ret <= 1'b0;
        if (!i_rst_n) begin
            busy <= 1'b0;
            w <= '0;
            gap <= '0;
        end else begin
            if (busy || !i_en || !i_cpu.irq) begin
                w <= '0;
            end else if (w == i_delay) begin
                o_ack <= 1'b1;
                busy <= 1'b1;
            end else begin
                w <= w + 3'h1;
            end
            if (i_cpu.entry_done) begin
                gap <= 2'h2;
            end else if (gap != 2'h0) begin
                gap <= gap - 2'h1;
                o_ret <= (gap == 2'h1);
            end
            if (i_cpu.ret_done) begin
                busy <= 1'b0;
            end
        end
    end
endmodule

/* File: bench/vpi_ctrl_tb_top.sv */
`timescale 1ns/100ps
module vpi_ctrl_tb_top;
    import vpi_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    vpi_wb_req_t wb = '0;
    vpi_wb_rsp_t rsp;
    logic [NUM_IRQ-1:0] irq = '0;
    logic [NUM_TRAPS-1:0] trap = '0;
    logic [LVL_W-1:0] lvl = '0;
    logic en = 1'b0;
    logic [2:0] dly = 3'h0;
    logic ack;
    logic ret;
    logic o_int;
    vpi_cpu_out_t cpu;
    logic [31:0] rd;
    int fails = 0;
    int n_checks = 0;
    vpi_ctrl i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wb(wb), .o_wb(rsp), .i_irq(irq),
        .i_trap(trap), .i_cpu_level(lvl), .i_ack(ack), .i_ret(ret), .o_cpu(cpu),
        .o_int(o_int));
    vpi_core_model i_core (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_en(en), .i_delay(dly),
        .i_cpu(cpu), .o_ack(ack), .o_ret(ret));
    initial begin
        forever #5 i_clk = ~i_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one classic cycle; an idle cycle after it keeps the minimum spacing
    task automatic wb_rw(input logic we, input logic [ADR_W-1:0] a, input logic [31:0] d);
        wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
        @(posedge i_clk);
        while (rsp.ack !== 1'b1) @(posedge i_clk);
        rd = rsp.dat;
        wb <= '0;
        @(posedge i_clk);
    endtask
    task automatic rchk(input logic [ADR_W-1:0] a, input logic [31:0] exp);
        wb_rw(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    // waits for a presented request, lets the core take it and return
    task automatic take(input logic [7:0] v, input logic [3:0] l, input logic [23:0] f,
        input logic [23:0] h);
        repeat (2) @(posedge i_clk);
        while (cpu.irq !== 1'b1) @(posedge i_clk);
        check(cpu.req_vec, v);
        check(cpu.req_level, l);
        en <= 1'b1;
        while (cpu.entry_done !== 1'b1) @(posedge i_clk);
        check(cpu.fetch_addr, f);
        check(cpu.handler, h);
        en <= 1'b0;
        while (cpu.ret_done !== 1'b1) @(posedge i_clk);
        dly <= dly + 3'h3;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        #200000;
        fails++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        rchk(ADDR_PRIO_BASE + 12'h018, 32'h4444);
        wb_rw(1'b1, ADDR_PRIO_BASE + 12'h018, 32'hFFFF);
        rchk(ADDR_PRIO_BASE + 12'h018, 32'h7777);
        rchk(ADDR_STATUS, 32'h0);
        rchk(12'h7F0, 32'h0);
        $display("test registers done");
        wb_rw(1'b1, 12'h82C, 32'h123456);
        wb_rw(1'b1, 12'hA24, 32'h654321);
        wb_rw(1'b1, 12'hA2C, 32'hABCDEF);
        wb_rw(1'b1, ADDR_EVT_MASK, 32'h1);
        irq[3] <= 1'b1;
        irq[5] <= 1'b1;
        take(8'd11, 4'd4, 24'h00001A, 24'h123456);
        check(o_int, 1'b1);
        rchk(ADDR_STATUS, 32'h0403);
        wb_rw(1'b1, ADDR_EVT_STATUS, 32'h1);
        check(o_int, 1'b0);
        $display("test tie done");
        wb_rw(1'b1, ADDR_PRIO_BASE + 12'h004, 32'h4744);
        wb_rw(1'b1, ADDR_CTRL_TWO, 32'h8000);
        take(8'd13, 4'd7, 24'h00011A, 24'hABCDEF);
        wb_rw(1'b1, ADDR_PRIO_BASE + 12'h004, 32'h4404);
        take(8'd11, 4'd4, 24'h000116, 24'h654321);
        irq <= '0;
        wb_rw(1'b1, ADDR_CTRL_TWO, 32'h0);
        $display("test levels done");
        lvl <= 4'd7;
        irq[0] <= 1'b1;
        repeat (3) @(posedge i_clk);
        check(cpu.irq, 1'b0);
        rchk(ADDR_STATUS, 32'h8403);
        wb_rw(1'b1, ADDR_STATUS, 32'h2000);
        rchk(ADDR_STATUS, 32'hA400);
        rchk(ADDR_EVT_STATUS, 32'h5);
        wb_rw(1'b1, ADDR_EVT_STATUS, 32'h7);
        rchk(ADDR_EVT_STATUS, 32'h0);
        lvl <= 4'd3;
        take(8'd8, 4'd4, 24'h000014, 24'h0);
        $display("test unacked done");
        lvl <= 4'd15;
        trap[2] <= 1'b1;
        take(8'd2, 4'd13, 24'h000008, 24'h0);
        trap <= '0;
        repeat (2) @(posedge i_clk);
        rchk(ADDR_STATUS, 32'hAD00);
        $display("test trap done");
        wrap_up();
    end
endmodule
